/* common/cxw_pkg.sv */
// package for the crosspoint write-only two-wire control port
package cxw_pkg;
  localparam logic [5:0] ADDR_LOW_BITS = 6'h06;
  localparam logic [7:0] REG_ROUTE_1_2 = 8'h00;
  localparam logic [7:0] REG_ROUTE_3_4 = 8'h01;
  localparam logic [7:0] REG_ROUTE_5_6 = 8'h02;
  localparam logic [7:0] REG_FRONTEND = 8'h03;
  localparam logic [7:0] REG_GAIN = 8'h04;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [3:0] SEL_MAX = 4'h8;
  localparam int NUM_INPUTS = 8;
  localparam int NUM_OUTPUTS = 6;
  localparam int SCL_FREQ_KHZ = 100;
  localparam logic [3:0] BIT_COUNT_ACK = 4'h8;

  typedef enum logic [4:0] {
    CXW_IDLE = 5'b00001,
    CXW_ADDR = 5'b00010,
    CXW_PTR = 5'b00100,
    CXW_DATA = 5'b01000,
    CXW_IGNORE = 5'b10000
  } cxw_phase_t;

  // link-side state, clocked on scl
  typedef struct packed {
    cxw_phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic first_data;
    logic ack_pending;
    logic commit_pend;
    logic commit_tgl;
    logic sda_drive;
  } cxw_link_t;

  // register file on clk_i
  typedef struct packed {
    logic [7:0] route_1_2;
    logic [7:0] route_3_4;
    logic [7:0] route_5_6;
    logic [7:0] frontend;
    logic [7:0] gain;
    logic [2:0] tgl_sync;
  } cxw_regs_t;
endpackage

/* hdl/cxw_write_port.sv */
// write-only two-wire control port and register set of an 8x6 crosspoint
`timescale 1ns/10ps
// How it works
// [R1] answer address 000110 plus two select pins
// [R2] first byte after start is the address
// [R3] write carries pointer byte then data byte
// [R4] no read path, registers are write only
// [R5] writes to undefined pointers change nothing
// [R6] registers 0-2 hold output pair selections
// [R7] selection 0 off, 1..8 inputs, reset off
// [R8] off selection powers down output amplifier
// [R9] many outputs may share one input
// [R10] register 3 picks clamp or bias per input
// [R11] frontend mode kept apart from routing
// [R12] register 4 low six bits pick gain
// [R13] link runs standard speed around 100 kHz
// [R14] sda stable while scl high, else control
// [R15] start and stop detected anywhere
// [R16] master starts only on idle bus
// [R17] pull sda low through ninth pulse
// [R18] any byte count, each byte acknowledged
// [R19] wrong address or read: release, ignore
// [R20] extra data bytes acked, not stored
// [R21] codes 9..15 off; apply after ack
module cxw_write_port (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic slave_select_pin_low_i,
  input wire logic slave_select_pin_high_i,
  output logic [cxw_pkg::NUM_OUTPUTS*4-1:0] route_sel_o,
  output logic [cxw_pkg::NUM_OUTPUTS-1:0] amp_powerdown_o,
  output logic [cxw_pkg::NUM_INPUTS-1:0] frontend_clamp_o,
  output logic [cxw_pkg::NUM_OUTPUTS-1:0] gain_zero_db_o
);
  import cxw_pkg::*;

  // reset crossing into the link domain: scl only ticks during frames,
  // so reset is applied asynchronously there, released after two scl rising edges
  logic [1:0] rst_link_q;
  logic nrst_link;
  always_ff @(posedge scl_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_link_q <= 2'b00;
    end else begin
      rst_link_q <= {rst_link_q[0], 1'b1};
    end
  end
  assign nrst_link = rst_link_q[1];

  // address straps come from pins: two flops in the link domain before use
  logic [1:0] pin_lo_q;
  logic [1:0] pin_hi_q;
  always_ff @(posedge scl_i or negedge nrst_link) begin
    if (!nrst_link) begin
      pin_lo_q <= 2'b00;
      pin_hi_q <= 2'b00;
    end else begin
      pin_lo_q <= {pin_lo_q[0], slave_select_pin_low_i};
      pin_hi_q <= {pin_hi_q[0], slave_select_pin_high_i};
    end
  end

  // start/stop detection on sda edges while scl high (see [R14]) (see [R15])
  // both are toggles so that a stop left pending cannot kill the next frame
  logic start_flag;
  logic stop_flag;
  logic start_clr_q;
  logic stop_clr_q;
  logic stop_pend;
  always_ff @(negedge sda_i or negedge nrst_link) begin
    if (!nrst_link) begin
      start_flag <= 1'b0;
    end else if (scl_i) begin
      start_flag <= ~start_clr_q;
    end
  end
  always_ff @(posedge sda_i or negedge nrst_link) begin
    if (!nrst_link) begin
      stop_flag <= 1'b0;
    end else if (scl_i) begin
      stop_flag <= ~stop_clr_q;
    end
  end
  assign stop_pend = stop_flag != stop_clr_q;

  cxw_link_t l_q;
  cxw_link_t l_d;
  logic [7:0] shifted;
  logic [7:0] addr_match;

  assign shifted = {l_q.shift[6:0], sda_i};
  // see [R1]
  assign addr_match = {pin_hi_q[1], pin_lo_q[1], ADDR_LOW_BITS};

  always_comb begin
    l_d = l_q;
    if (start_flag != start_clr_q) begin
      // fresh start seen: this rising edge is the address MSB (see [R2])
      l_d.phase = CXW_ADDR;
      l_d.bit_cnt = 4'h1;
      l_d.shift = {7'h00, sda_i};
      l_d.first_data = 1'b1;
      l_d.ack_pending = 1'b0;
    end else if (stop_pend || l_q.phase == CXW_IDLE || l_q.phase == CXW_IGNORE) begin
      l_d.phase = (stop_pend) ? CXW_IDLE : l_q.phase;
    end else if (l_q.bit_cnt == BIT_COUNT_ACK) begin
      // ninth pulse: ack high time; byte was handled on the eighth rising edge
      l_d.bit_cnt = 4'h0;
    end else begin
      l_d.shift = shifted;
      l_d.bit_cnt = l_q.bit_cnt + 4'h1;
      if (l_q.bit_cnt == 4'h7) begin
        l_d.ack_pending = 1'b1;
        unique case (l_q.phase)
          CXW_ADDR: begin
            // see [R19]: read bit or mismatch ignores until next start
            if (shifted[7:1] != addr_match[7:1] || shifted[0] || addr_match[0]) begin
              l_d.phase = CXW_IGNORE;
              l_d.ack_pending = 1'b0;
            end else begin
              l_d.phase = CXW_PTR;
            end
          end
          CXW_PTR: begin
            l_d.ptr = shifted; // see [R3]
            l_d.phase = CXW_DATA;
          end
          CXW_DATA: begin
            // see [R20]: only the first data byte is stored; see [R18]
            if (l_q.first_data) begin
              l_d.wdata = shifted;
              l_d.commit_pend = ~l_q.commit_pend;
            end
            l_d.first_data = 1'b0;
          end
          default: l_d.phase = l_q.phase;
        endcase
      end
    end
  end

  always_ff @(posedge scl_i or negedge nrst_link) begin
    if (!nrst_link) begin
      l_q <= '{phase: CXW_IDLE, default: '0};
      start_clr_q <= 1'b0;
      stop_clr_q <= 1'b0;
    end else begin
      // link logic runs only on scl edges, any standard rate (see [R13])
      l_q <= l_d;
      start_clr_q <= start_flag;
      stop_clr_q <= stop_flag;
    end
  end

  // falling edge drives sda for the ack pulse and posts commits
  logic drive_q;
  logic tgl_q;
  logic commit_seen_q;
  always_ff @(negedge scl_i or negedge nrst_link) begin
    if (!nrst_link) begin
      drive_q <= 1'b0;
      tgl_q <= 1'b0;
      commit_seen_q <= 1'b0;
    end else begin
      // see [R17]: low from fall after bit 8 to fall after pulse 9
      drive_q <= l_q.ack_pending && l_q.bit_cnt == BIT_COUNT_ACK
                 && l_q.phase != CXW_IGNORE && l_q.phase != CXW_IDLE;
      // see [R21]: value released once the ack pulse has ended
      if (l_q.commit_pend != commit_seen_q && l_q.bit_cnt == 4'h0) begin
        tgl_q <= ~tgl_q;
        commit_seen_q <= l_q.commit_pend;
      end
    end
  end
  // commit_pend is a toggle request: flip on each store
  // (edge-to-edge handshake avoids a two-domain driver)

  assign sda_o = 1'b0; // see [R4]: device only ever pulls low
  assign sda_oe_o = drive_q;

  // register file on clk_i, fed by toggle crossing of a stable word
  cxw_regs_t r_q;
  cxw_regs_t r_d;
  always_comb begin
    r_d = r_q;
    r_d.tgl_sync = {r_q.tgl_sync[1:0], tgl_q};
    if (r_q.tgl_sync[2] != r_q.tgl_sync[1]) begin
      unique case (l_q.ptr)
        REG_ROUTE_1_2: r_d.route_1_2 = l_q.wdata; // see [R6]
        REG_ROUTE_3_4: r_d.route_3_4 = l_q.wdata;
        REG_ROUTE_5_6: r_d.route_5_6 = l_q.wdata;
        REG_FRONTEND: r_d.frontend = l_q.wdata; // see [R10] [R11]
        REG_GAIN: r_d.gain = l_q.wdata; // see [R12]
        default: r_d = r_d; // see [R5]
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      r_q <= '{default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // per-output decode; shared selections allowed (see [R9])
  logic [47:0] route_all;
  assign route_all = {r_q.route_5_6, r_q.route_3_4, r_q.route_1_2, 24'h000000};
  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_out
      logic [3:0] sel;
      assign sel = route_all[24 + g*4 +: 4];
      // see [R7] [R21]: out of range codes read as off
      assign route_sel_o[g*4 +: 4] = (sel > SEL_MAX) ? SEL_OFF : sel;
      assign amp_powerdown_o[g] = (sel == SEL_OFF) || (sel > SEL_MAX); // see [R8]
    end
  endgenerate
  assign frontend_clamp_o = r_q.frontend;
  assign gain_zero_db_o = r_q.gain[5:0];
endmodule

/* sim/cxw_write_port_properties.sv */
// port assertions for the crosspoint write port
`timescale 1ns/10ps
module cxw_write_port_properties (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic [23:0] route_sel_o,
  input wire logic [5:0] amp_powerdown_o,
  input wire logic [7:0] frontend_clamp_o,
  input wire logic [5:0] gain_zero_db_o
);
  import cxw_pkg::*;
  logic [5:0] off_w;
  logic big_w;
  always_comb begin
    off_w = 6'h0;
    big_w = 1'b0;
    for (int k = 0; k < NUM_OUTPUTS; k++) begin
      off_w[k] = route_sel_o[4*k+:4] == SEL_OFF;
      big_w = big_w | (route_sel_o[4*k+:4] > SEL_MAX);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_off_powerdown: assert property (amp_powerdown_o == off_w)
    else $error("powerdown wrong");
  chk_sel_range: assert property (!big_w)
    else $error("selection above range");
  chk_reset_clear: assert property ($rose(nrst_i) |->
    {route_sel_o, frontend_clamp_o, gain_zero_db_o} == 38'h0) else $error("reset value");
  chk_ack_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("ack raised with scl high");
  chk_ack_length: assert property ($rose(sda_oe_o) |-> sda_oe_o [*6] ##[1:4] !sda_oe_o)
    else $error("ack length");
  chk_ack_held_high: assert property ($rose(scl_i) && sda_oe_o |-> sda_oe_o [*3])
    else $error("ack dropped in pulse");
  chk_commit_after_ack: assert property ($changed({route_sel_o, frontend_clamp_o,
    gain_zero_db_o}) |-> !sda_oe_o && $past(sda_oe_o, 6)) else $error("update timing");
  chk_mode_kept: assert property ($changed(route_sel_o) |-> $stable(frontend_clamp_o))
    else $error("mode moved with route");
endmodule
bind cxw_write_port cxw_write_port_properties cxw_write_port_properties_i (
  .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
  .route_sel_o(route_sel_o), .amp_powerdown_o(amp_powerdown_o),
  .frontend_clamp_o(frontend_clamp_o), .gain_zero_db_o(gain_zero_db_o));

/* sim/cxw_master.sv */
// bus master model writing the crosspoint control port
`timescale 1ns/10ps
module cxw_master (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  initial {scl_o, sda_o} = 2'b11;
  // two idle pulses with sda high so link flops leave reset without a condition
  task automatic wake();
    repeat (4) #40 scl_o = ~scl_o;
  endtask
  task automatic start(); // idle bus on entry
    #40 sda_o = 1'b0;
    #40 scl_o = 1'b0;
  endtask
  task automatic stop();
    #20 sda_o = 1'b0;
    #20 scl_o = 1'b1;
    #20 sda_o = 1'b1;
    #40;
  endtask
  // msb first; sda moves only while scl is low, released on the ninth pulse
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      #20 sda_o = i ? b[i-1] : 1'b1;
      #20 scl_o = 1'b1;
      #20 ack = ~sda_i;
      #20 scl_o = 1'b0;
    end
  endtask
endmodule

/* sim/cxw_write_port_tb.sv */
// self-checking bench for the crosspoint write port
`timescale 1ns/10ps
module cxw_write_port_tb;
  import cxw_pkg::*;
  logic clk_i = 0, nrst_i = 0, sel_lo = 0, sel_hi = 0, oe, so, ack, scl, ms;
  logic [23:0] rt;
  logic [5:0] pd, gn;
  logic [7:0] cl, r[5] = '{default: 8'h0};
  logic [43:0] seen = 44'hFC000, last = 44'hFC000, q[$];
  int n_mismatch = 0, checks = 0, cyc = 0, i, k;
  integer seed = 32'hd3ea;
  wire sda = ms & ~(oe & ~so);
  initial forever #5 clk_i = ~clk_i;
  cxw_master cxw_master_i (.scl_o(scl), .sda_o(ms), .sda_i(sda));
  cxw_write_port cxw_write_port_i (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl),
    .sda_i(sda), .sda_o(so), .sda_oe_o(oe), .slave_select_pin_low_i(sel_lo),
    .slave_select_pin_high_i(sel_hi), .route_sel_o(rt), .amp_powerdown_o(pd),
    .frontend_clamp_o(cl), .gain_zero_db_o(gn));
  task automatic check(input string nm, input logic [43:0] s, e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [43:0] vec();
    logic [43:0] v;
    logic [3:0] s;
    v = {30'h0, r[3], r[4][5:0]};
    for (int j = 0; j < 6; j++) begin
      s = r[j/2][4*(j%2)+:4];
      if (s > SEL_MAX) s = 4'h0;
      v[20+4*j+:4] = s;
      v[14+j] = s == 4'h0;
    end
    return v;
  endfunction
  task automatic tx(input logic [7:0] b, input logic ok);
    cxw_master_i.put(b, ack);
    check("ack", 44'(ack), 44'(ok));
  endtask
  task automatic wr(input logic [7:0] a, p, d, input int n, input logic ok);
    cxw_master_i.start();
    tx(a, ok);
    tx(p, ok);
    if (ok && p < 5) r[p] = d;
    if (vec() !== last) q.push_back(vec());
    last = vec();
    repeat (n) begin
      tx(d, ok);
      d = ~d;
    end
    cxw_master_i.stop();
  endtask
  // outputs only move on a committed write, so each change consumes one note
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test();
    end
    if (nrst_i && {rt, pd, cl, gn} !== seen) begin
      seen = {rt, pd, cl, gn};
      check("outputs", seen, q.size() ? q.pop_front() : 44'hX);
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    cxw_master_i.wake();
    for (i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {sel_hi, sel_lo} <= 2'(i);
      for (k = 0; k < 5; k++) wr({2'(i), 6'h06}, 8'(k), 8'($random(seed)), 1, 1);
      wr({~2'(i), 6'h06}, 8'h00, 8'h11, 1, 0);
      wr({2'(i), 6'h07}, 8'h00, 8'h22, 1, 0);
      wr({2'(i), 6'h06}, 8'(5 + i * 83), 8'h33, 1, 1);
      wr({2'(i), 6'h06}, 8'(i), 8'($random(seed)), 3, 1);
    end
    for (i = 0; i < 16; i++) wr({sel_hi, sel_lo, 6'h06}, 8'(i % 3), {2{4'(i)}}, 1, 1);
    repeat (50) @(posedge clk_i);
    check("pending", 44'(q.size()), 44'h0);
    end_of_test();
  end
endmodule
